// File: dv/rtpi_timer_tb.sv
// testbench: register-level tests of the ripple timer with periodic interrupt
`timescale 1ns/1ps
module ripple_timer_periodic_interrupt_tb_top;
  // ===========================================================
  // stimulus and observation
  logic        clk_sys_i;
  logic        rst_i;
  logic        ext_reset_i;
  logic        clk_switching_i;
  logic [7:0]  addr_i;
  logic [7:0]  wdata_i;
  logic        wr_i;
  logic        rd_i;
  logic [7:0]  rdata_o;
  logic        irq_o;
  logic        por_busy_o;
  int          fails;
  int          check_count;
  int          cyc = 0;
  int          t1;
  int          t2;
  logic [7:0]  r;
  logic [7:0]  r2;
  localparam int POR_SIM = 16;  // short power-on count keeps the run brief
  localparam logic [7:0] CS = rtpi_pkg::ADDR_CTRL_STATUS;
  localparam logic [7:0] CV = rtpi_pkg::ADDR_COUNT_VALUE;

  rtpi_timer #(.POR_COUNT(POR_SIM)) rtpi_timer_inst (
    .clk_sys_i       (clk_sys_i),
    .rst_i           (rst_i),
    .ext_reset_i     (ext_reset_i),
    .clk_switching_i (clk_switching_i),
    .addr_i          (addr_i),
    .wdata_i         (wdata_i),
    .wr_i            (wr_i),
    .rd_i            (rd_i),
    .rdata_o         (rdata_o),
    .irq_o           (irq_o),
    .por_busy_o      (por_busy_o)
  );

  // ===========================================================
  // clock and cycle count, the time base for all period checks
  initial clk_sys_i = 1'b0;
  always #2 clk_sys_i = ~clk_sys_i;
  always @(posedge clk_sys_i) cyc <= cyc + 1;

  // ===========================================================
  // helpers
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge clk_sys_i);
    wr_i    <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe is taken
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_sys_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge clk_sys_i);
    rd_i   <= 1'b0;
    #1 d = rdata_o;
  endtask

  // bounded wait for irq_o to reach a level, sampled mid-cycle
  task automatic wait_lvl(input logic lvl, input int lim, output int t);
    int n;
    n = 0;
    @(negedge clk_sys_i);
    while (irq_o !== lvl && n < lim) begin
      @(negedge clk_sys_i);
      n++;
    end
    if (n >= lim) check(32'h0, 32'h1);
    t = cyc;
  endtask

  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // watchdog: the last periodic event lands near cycle 98,400
  initial begin
    repeat (100000) @(posedge clk_sys_i);
    fails++;
    give_verdict;
  end

  // ===========================================================
  // test sequence
  initial begin
    fails = 0; check_count = 0;
    rst_i = 1'b1; ext_reset_i = 1'b0; clk_switching_i = 1'b0;
    addr_i = 8'h00; wdata_i = 8'h00; wr_i = 1'b0; rd_i = 1'b0;
    repeat (16) @(posedge clk_sys_i);
    check(por_busy_o, 1'b1);
    rst_i <= 1'b0;
    t1 = cyc;
    wait_lvl(1'b0, 1, t2);  // irq low at the first sample after reset release
    while (por_busy_o !== 1'b0 && cyc - t1 < 100) @(negedge clk_sys_i);
    check((cyc - t1 >= POR_SIM) && (cyc - t1 <= POR_SIM + 4), 1'b1);
    rd(CV, r);
    check(r < 8'h03, 1'b1);
    rd(CS, r);
    check(r, 8'h03);
    rd(8'h0A, r);
    check(r, 8'h00);
    $display("test reset done");
    // writable fields, acks read zero; the flag bits written are masked from the check
    for (int c = 0; c < 4; c++) begin
      wr(CS, 8'hFC | c[7:0]);
      rd(CS, r);
      check(r & 8'h3F, 8'h30 | c);
    end
    wr(CS, 8'h03);
    $display("test fields done");
    // counter pace over 40 cycles, with a write to the read-only count
    rd(CV, r);
    wr(CV, 8'h55);
    repeat (36) @(posedge clk_sys_i);
    rd(CV, r2);
    check(8'(r2 - r), 8'h0A);
    // clock switch freezes the chain
    @(posedge clk_sys_i) clk_switching_i <= 1'b1;
    repeat (8) @(posedge clk_sys_i);
    rd(CV, r);
    repeat (38) @(posedge clk_sys_i);
    rd(CV, r2);
    check(r2, r);
    @(posedge clk_sys_i) clk_switching_i <= 1'b0;
    $display("test counter done");
    // overflow flag, interrupt, acknowledge and period
    wr(CS, 8'h23);
    wait_lvl(1'b1, 1100, t1);
    rd(CS, r);
    check(r, 8'hA3);
    wr(CS, 8'h2B);
    wait_lvl(1'b0, 8, t2);
    wait_lvl(1'b1, 1100, t2);
    check(t2 - t1, 1024);
    wr(CS, 8'h03);
    repeat (1100) @(posedge clk_sys_i);
    check(irq_o, 1'b0);
    rd(CS, r);
    check(r, 8'h83);
    wr(CS, 8'h0B);
    rd(CS, r);
    check(r, 8'h03);
    $display("test overflow done");
    // periodic flag for the two shortest rates
    for (int c = 0; c < 2; c++) begin
      // rate moves right after an event, far from the next tap
      wr(CS, 8'h10 | c[7:0]);
      wait_lvl(1'b1, (1 << (15 + c)) + 16, t1);
      rd(CS, r);
      check(r & 8'h40, 8'h40);
      wr(CS, 8'h14 | c[7:0]);
      wait_lvl(1'b0, 8, t2);
      wait_lvl(1'b1, (1 << (14 + c)) + 16, t2);
      check(t2 - t1, 1 << (14 + c));
      wr(CS, 8'h0F);
    end
    $display("test periodic done");
    // external reset clears flags, enables and chain, restores rate
    wr(CS, 8'h30);
    ext_reset_i <= 1'b1;
    repeat (6) @(posedge clk_sys_i);
    ext_reset_i <= 1'b0;
    repeat (3) @(posedge clk_sys_i);
    rd(CS, r);
    check(r, 8'h03);
    rd(CV, r);
    check(r < 8'h03, 1'b1);
    $display("test external reset done");
    give_verdict;
  end
endmodule

// File: rtl/rtpi_pkg.sv
// package: constants for the ripple timer with periodic interrupt
package rtpi_pkg;
  // ===========================================================
  // register map
  localparam logic [7:0] ADDR_CTRL_STATUS = 8'h08;
  localparam logic [7:0] ADDR_COUNT_VALUE = 8'h09;
  // ===========================================================
  // control/status field positions
  localparam int BIT_OVF_FLAG = 7;
  localparam int BIT_PER_FLAG = 6;
  localparam int BIT_OVF_IE   = 5;
  localparam int BIT_PER_IE   = 4;
  localparam int BIT_OVF_ACK  = 3;
  localparam int BIT_PER_ACK  = 2;
  localparam int BIT_RATE_HI  = 1;
  localparam int BIT_RATE_LO  = 0;
  // ===========================================================
  // reset values
  localparam logic [1:0] RATE_RESET     = 2'h3;
  localparam logic [7:0] COUNT_RESET    = 8'h00;
  // ===========================================================
  // chain timing, in bus clock cycles
  localparam int PRESCALE_BITS  = 2;   // divide by four
  localparam int COUNTER_BITS   = 8;   // readable stage
  localparam int PERIODIC_BASE  = 14;  // first periodic tap, 2^14
  localparam int CHAIN_BITS     = 17;  // longest tap, 2^17
  localparam int POR_CYCLES     = 4064;
  localparam int POR_BITS       = 12;
endpackage

// File: rtl/rtpi_timer.sv
// module: ripple timer chain with overflow and periodic interrupt
//
// Functional notes
// (RULE_01) overflow flag sets when the 8-bit counter wraps all-ones to zero
// (RULE_02) interrupt request while overflow flag and overflow enable are set
// (RULE_03) overflow ack write of one clears flag; ack reads zero
// (RULE_04) any reset clears both flags and both enables
// (RULE_05) periodic circuit runs at bus clock/8192 with four divider stages
// (RULE_06) periodic flag sets when the selected stage output goes active
// (RULE_07) periodic flag with enable requests; periodic ack clears, reads zero
// (RULE_08) rate codes 00..11 give 2^14..2^17 bus clock periods
// (RULE_09) reset sets rate select to 11, the longest period
// (RULE_10) software avoids changing rate near timeout; flags may slip
// (RULE_11) count register is read-only, advancing every four bus clocks
// (RULE_12) power-up clears chain, counts 4064 cycles, clears again, releases
// (RULE_13) after power-on release counter counts up from zero
// (RULE_14) external reset outside power-on clears the whole chain
// (RULE_15) chain holds still while the bus clock source switches
// (RULE_16) counter overflow recurs every 1024 bus clock cycles
// (RULE_17) counter fed by fixed divide-by-four prescaler
// (RULE_18) control/status at 0x08, count value at 0x09
// (RULE_19) bits: flags 7,6; enables 5,4; acks 3,2; rate 1,0
// (RULE_20) enables and rate are read/write; flag bits ignore writes
//
// The implementer's own choices: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
module rtpi_timer #(
  parameter int POR_COUNT = rtpi_pkg::POR_CYCLES
) (
  // clock and resets
  input  wire logic       clk_sys_i,
  input  wire logic       rst_i,
  input  wire logic       ext_reset_i,
  // clock-source switch in progress, from the clock selector
  input  wire logic       clk_switching_i,
  // register port
  input  wire logic [7:0] addr_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic       wr_i,
  input  wire logic       rd_i,
  output logic      [7:0] rdata_o,
  // status outputs
  output logic            irq_o,
  output logic            por_busy_o
);

  // ===========================================================
  // input synchronisers
  logic [1:0] ext_sync;
  logic [1:0] sw_sync;
  logic       ext_rst;
  logic       switching;

  // both pins arrive from outside this clock domain
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      ext_sync <= 2'h0;
      sw_sync  <= 2'h0;
    end else begin
      ext_sync <= {ext_sync[0], ext_reset_i};
      sw_sync  <= {sw_sync[0], clk_switching_i};
    end
  end
  assign ext_rst   = ext_sync[1];
  assign switching = sw_sync[1];

  // ===========================================================
  // helpers
  // tap index for a rate code: 2^(14+code) cycles per periodic event
  function automatic logic [4:0] tap_of(input logic [1:0] code);
    tap_of = 5'(rtpi_pkg::PERIODIC_BASE - 1) + 5'(code);
  endfunction

  function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
    hit = (a == b);
  endfunction

  // ===========================================================
  // power-on sequencer and divider chain
  logic [rtpi_pkg::POR_BITS-1:0]   por_cnt;
  logic [rtpi_pkg::POR_BITS-1:0]   next_por_cnt;
  logic                            por_busy;
  logic                            next_por_busy;
  logic [rtpi_pkg::CHAIN_BITS-1:0] chain;
  logic [rtpi_pkg::CHAIN_BITS-1:0] next_chain;
  logic                            chain_clear;
  logic                            advance;

  // the chain clears on entry to, release of, and any external reset
  assign chain_clear = por_busy || ext_rst;              // see RULE_14
  // frozen while the bus clock changes source, as the real clock is low
  assign advance     = !switching;                       // see RULE_15

  always_comb begin
    next_por_cnt  = por_cnt;
    next_por_busy = por_busy;
    next_chain    = chain;
    if (por_busy) begin
      // power-on count; the chain is held clear, released at the end
      next_chain = '0;                                   // see RULE_12
      if (advance) begin
        next_por_cnt = por_cnt + 1'b1;
      end
      if (por_cnt == rtpi_pkg::POR_BITS'(POR_COUNT - 1)) begin
        next_por_busy = 1'b0;                            // see RULE_12
      end
    end else if (chain_clear) begin
      next_chain = '0;                                   // see RULE_14
    end else if (advance) begin
      // prescaler is chain[1:0], counter chain[9:2]
      next_chain = chain + 1'b1;             // see RULE_13 RULE_17
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      por_cnt  <= '0;
      por_busy <= 1'b1;
      chain    <= '0;
    end else begin
      por_cnt  <= next_por_cnt;
      por_busy <= next_por_busy;
      chain    <= next_chain;
    end
  end

  // ===========================================================
  // chain events
  logic [7:0] count_value;
  logic       ovf_event;
  logic       per_event;
  logic [4:0] tap;

  assign count_value = chain[9:2];                       // see RULE_11
  // wrap from FF to 00 happens every 1024 bus cycles
  assign ovf_event = advance && !chain_clear &&
                     (chain[9:0] == 10'h3FF);      // see RULE_01 RULE_16

  // ===========================================================
  // control/status register
  logic       ovf_flag;
  logic       per_flag;
  logic       ovf_ie;
  logic       per_ie;
  logic [1:0] rate_sel;
  logic       next_ovf_flag;
  logic       next_per_flag;
  logic       next_ovf_ie;
  logic       next_per_ie;
  logic [1:0] next_rate_sel;
  logic       cs_wr;

  assign cs_wr = wr_i &&
                 hit(addr_i, rtpi_pkg::ADDR_CTRL_STATUS); // see RULE_18
  assign tap = tap_of(rate_sel);                         // see RULE_08
  // the selected stage goes active when all bits below and at it are ones;
  // taps sit after bit 12, i.e. beyond the /8192 point
  assign per_event = advance && !chain_clear &&
                     (chain & ((17'h1 << (tap + 5'h1)) - 17'h1)) ==
                     ((17'h1 << (tap + 5'h1)) - 17'h1);  // see RULE_05 RULE_06

  // a set in the same cycle as an ack wins, so no event is lost
  always_comb begin
    next_ovf_flag = ovf_flag;
    next_per_flag = per_flag;
    next_ovf_ie   = ovf_ie;
    next_per_ie   = per_ie;
    next_rate_sel = rate_sel;
    if (cs_wr) begin
      next_ovf_ie   = wdata_i[rtpi_pkg::BIT_OVF_IE];     // see RULE_20
      next_per_ie   = wdata_i[rtpi_pkg::BIT_PER_IE];
      next_rate_sel = {wdata_i[rtpi_pkg::BIT_RATE_HI],
                       wdata_i[rtpi_pkg::BIT_RATE_LO]};  // see RULE_19
      if (wdata_i[rtpi_pkg::BIT_OVF_ACK]) begin
        next_ovf_flag = 1'b0;                            // see RULE_03
      end
      if (wdata_i[rtpi_pkg::BIT_PER_ACK]) begin
        next_per_flag = 1'b0;                            // see RULE_07
      end
    end
    if (ovf_event) begin
      next_ovf_flag = 1'b1;                              // see RULE_01
    end
    if (per_event) begin
      next_per_flag = 1'b1;                              // see RULE_06
    end
    if (ext_rst || por_busy) begin
      // external and power-on reset clear flags and enables
      next_ovf_flag = 1'b0;                              // see RULE_04
      next_per_flag = 1'b0;
      next_ovf_ie   = 1'b0;
      next_per_ie   = 1'b0;
      next_rate_sel = rtpi_pkg::RATE_RESET;              // see RULE_09
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      ovf_flag <= 1'b0;                                  // see RULE_04
      per_flag <= 1'b0;
      ovf_ie   <= 1'b0;
      per_ie   <= 1'b0;
      rate_sel <= rtpi_pkg::RATE_RESET;                  // see RULE_09
    end else begin
      ovf_flag <= next_ovf_flag;
      per_flag <= next_per_flag;
      ovf_ie   <= next_ovf_ie;
      per_ie   <= next_per_ie;
      rate_sel <= next_rate_sel;
    end
  end

  // ===========================================================
  // read data, interrupt and status outputs
  logic [7:0] next_rdata;
  logic       next_irq;

  always_comb begin
    next_rdata = 8'h00;
    if (rd_i && hit(addr_i, rtpi_pkg::ADDR_CTRL_STATUS)) begin
      // ack bits are write-only and read as zero
      next_rdata[rtpi_pkg::BIT_OVF_FLAG] = ovf_flag;     // see RULE_03
      next_rdata[rtpi_pkg::BIT_PER_FLAG] = per_flag;
      next_rdata[rtpi_pkg::BIT_OVF_IE]   = ovf_ie;
      next_rdata[rtpi_pkg::BIT_PER_IE]   = per_ie;
      next_rdata[rtpi_pkg::BIT_RATE_HI]  = rate_sel[1];
      next_rdata[rtpi_pkg::BIT_RATE_LO]  = rate_sel[0];
    end else if (rd_i && hit(addr_i, rtpi_pkg::ADDR_COUNT_VALUE)) begin
      next_rdata = count_value;                          // see RULE_11
    end
    // request follows the stored flags, one cycle behind them
    next_irq = (ovf_flag && ovf_ie) ||
               (per_flag && per_ie);                     // see RULE_02 RULE_07
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_o    <= 8'h00;
      irq_o      <= 1'b0;
      por_busy_o <= 1'b1;
    end else begin
      rdata_o    <= next_rdata;
      irq_o      <= next_irq;
      por_busy_o <= next_por_busy;
    end
  end

  // ===========================================================
  // assertions
  // the wrap and the tap event are the first step of each flag-set check
  sequence s_wrap;
    ovf_event;
  endsequence

  sequence s_periodic_tick;
    per_event;
  endsequence

  a_ovf_flag_set: assert property (                     // see RULE_01
    @(posedge clk_sys_i) disable iff (rst_i)
    (s_wrap and (!ext_rst && !por_busy)) |=> ovf_flag)
    else $error("overflow flag not set after wrap");

  a_per_flag_set: assert property (                     // see RULE_06
    @(posedge clk_sys_i) disable iff (rst_i)
    s_periodic_tick |=> per_flag)
    else $error("periodic flag not set after tap event");

  a_irq_ovf: assert property (                          // see RULE_02
    @(posedge clk_sys_i) disable iff (rst_i)
    ovf_flag && ovf_ie |=> irq_o)
    else $error("overflow irq missing");

  a_irq_per: assert property (                          // see RULE_07
    @(posedge clk_sys_i) disable iff (rst_i)
    per_flag && per_ie |=> irq_o)
    else $error("periodic irq missing");

  a_ovf_ack: assert property (                          // see RULE_03
    @(posedge clk_sys_i) disable iff (rst_i)
    cs_wr && wdata_i[rtpi_pkg::BIT_OVF_ACK] && !ovf_event |=> !ovf_flag)
    else $error("overflow ack did not clear flag");

  a_ext_clear: assert property (                        // see RULE_14
    @(posedge clk_sys_i) disable iff (rst_i)
    ext_rst |=> chain == '0 && !ovf_ie && !per_ie)
    else $error("external reset did not clear chain");

  a_count_step: assert property (                       // see RULE_11
    @(posedge clk_sys_i) disable iff (rst_i)
    !chain_clear && advance && chain[1:0] == 2'h3 ##1 !chain_clear
    |-> count_value == 8'($past(count_value) + 8'h01))
    else $error("counter did not step after four cycles");

  a_count_read: assert property (                       // see RULE_11
    @(posedge clk_sys_i) disable iff (rst_i)
    rd_i && addr_i == rtpi_pkg::ADDR_COUNT_VALUE
    |=> rdata_o == $past(count_value))
    else $error("count read returned a stale value");

  a_freeze_switch: assert property (                    // see RULE_15
    @(posedge clk_sys_i) disable iff (rst_i)
    switching && !chain_clear |=> chain == $past(chain))
    else $error("chain advanced during clock switch");

  a_per_ack: assert property (                          // see RULE_07
    @(posedge clk_sys_i) disable iff (rst_i)
    cs_wr && wdata_i[rtpi_pkg::BIT_PER_ACK] && !per_event |=> !per_flag)
    else $error("periodic ack did not clear flag");

  a_ack_reads_zero: assert property (                   // see RULE_03
    @(posedge clk_sys_i) disable iff (rst_i)
    rd_i ##1 1'b1 |-> rdata_o[3:2] == 2'h0 ||
    $past(addr_i) == rtpi_pkg::ADDR_COUNT_VALUE)
    else $error("ack bits read back non-zero");

  a_per_long: assert property (                         // see RULE_08
    @(posedge clk_sys_i) disable iff (rst_i)
    per_event && rate_sel == 2'h3 |-> chain[16:0] == 17'h1FFFF)
    else $error("longest rate event off the 2^17 boundary");

endmodule
